// ==== logic/cpc_pkg.sv ====
// Constants shared by the parallel pixel capture block.
// Assumes one 50 MHz system clock; the pixel clock is sampled as a plain input.
package cpc_pkg;

	localparam int          CLK_PERIOD_NS     = 20;
	localparam int          CLK_HZ            = 50_000_000;
	// Highest stream rate the capture port is specified for, in bytes per second
	localparam int          MAX_RATE_BPS      = 54_000_000;
	// Two synchroniser stages plus the edge detector need a pixel period of four clocks
	localparam int          PIX_MIN_CYCLES    = 4;
	localparam int          PIX_MIN_PERIOD_NS = PIX_MIN_CYCLES * CLK_PERIOD_NS;

	localparam int          ADDR_W            = 4;
	localparam int          PIX_W             = 14;
	localparam int          IN_W              = PIX_W + 3;

	localparam logic [3:0]  OFF_CTRL          = 4'h0;
	localparam logic [3:0]  OFF_STAT          = 4'h4;
	localparam logic [3:0]  OFF_DATA          = 4'h8;
	localparam logic [3:0]  OFF_CODE          = 4'hC;

	localparam int          B_CAPTURE         = 0;
	localparam int          B_EMBED           = 1;
	localparam int          B_COMPRESS        = 2;
	localparam int          B_FALL            = 3;
	localparam int          B_WIDTH           = 4;
	localparam int          B_FSYNC_LOW       = 6;
	localparam logic [31:0] CTRL_MASK         = 32'h0000007F;
	localparam logic [31:0] CTRL_RESET        = 32'h00000000;

	localparam int          B_FRAME_ACT       = 0;
	localparam int          B_LINE_ACT        = 1;
	localparam int          B_REQ             = 2;
	localparam int          B_OVERRUN         = 3;

	// Embedded codes: [7:0] frame start, [15:8] line start, [23:16] line end, [31:24] frame end
	localparam logic [31:0] CODE_RESET        = 32'hB69D80AB;
	localparam logic [7:0]  PRE_FF            = 8'hFF;
	localparam logic [7:0]  PRE_00            = 8'h00;

	typedef enum logic [1:0]
	{
		CPC_W8  = 2'b00,
		CPC_W10 = 2'b01,
		CPC_W12 = 2'b10,
		CPC_W14 = 2'b11
	} cpc_width_t;

endpackage

// ==== logic/cpc_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous levels; only the second stage is visible.
`timescale 1ns/1ps
module cpc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			q_o    <= '0;
		end
		else
		begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule // cpc_sync

// ==== logic/cpc_packer.sv ====
// Packs pixel samples into 32-bit words, first sample in the low bits.
// Assumes sample_valid_i is a one-cycle pulse per accepted sample.
`timescale 1ns/1ps
module cpc_packer
	import cpc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             restart_i,
	input  wire logic             flush_i,
	input  wire logic             wide_i,
	input  wire logic             sample_valid_i,
	input  wire logic [PIX_W-1:0] sample_i,
	output logic                  word_valid_o,
	output logic      [31:0]      word_o
);

	logic [31:0] acc_q;
	logic [1:0]  cnt_q;

	// Narrow samples take a byte lane each, wider ones a half-word
	wire  [4:0]  shift  = wide_i ? {cnt_q[0], 4'h0} : {cnt_q, 3'h0};
	wire  [31:0] ins    = wide_i ? {18'h0, sample_i} : {24'h0, sample_i[7:0]};
	wire  [31:0] acc_d  = acc_q | (ins << shift);
	wire         last   = wide_i ? cnt_q[0] : (cnt_q == 2'h3);
	wire  [31:0] acc_n  = sample_valid_i ? acc_d : acc_q;
	wire         emit   = (sample_valid_i && last) || (flush_i && (sample_valid_i || cnt_q != 2'h0));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_q        <= 32'h00000000;
			cnt_q        <= 2'h0;
			word_valid_o <= 1'b0;
			word_o       <= 32'h00000000;
		end
		else if (restart_i)
		begin
			acc_q        <= 32'h00000000;
			cnt_q        <= 2'h0;
			word_valid_o <= 1'b0;
		end
		else
		begin
			word_valid_o <= emit;
			if (emit)
			begin
				word_o <= acc_n;
				acc_q  <= 32'h00000000;
				cnt_q  <= 2'h0;
			end
			else if (sample_valid_i)
			begin
				acc_q <= acc_d;
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end

endmodule // cpc_packer

// ==== logic/cpc_capture.sv ====
// Parallel pixel capture port: samples the sensor stream, packs words, requests DMA.
// Assumes pixel pins arrive asynchronously and a DMA engine acknowledges each request.
//
// Contract
// - The pixel bus width is selectable as 8, 10, 12 or 14 bits and is sampled once per pixel clock.
// - A polarity bit picks the rising or falling pixel clock edge for sampling.
// - Samples are gathered into a 32-bit data word that the DMA side reads.
// - Every completed 32-bit word raises exactly one DMA request; with one pending, a new word overwrites its data and sets overrun instead.
// - No DMA request is raised while the capture bit is cleared.
// - Compressed-image reception runs only with control bit 2 set, otherwise data is line and frame pixels.
// - Synchronisation comes from discrete line and frame inputs or from codes embedded in the stream.
// - The block holds no image buffer; addressing and storage belong to the DMA engine.
// - In 8-bit mode the eight data inputs carry the sensor's eight most significant bits.
// - The receiver is meant to keep up with streams of up to 54 megabytes per second; the synchroniser caps the pixel clock at 12.5 MHz instead.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module cpc_capture
	import cpc_pkg::*;
(
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	input  wire logic [ADDR_W-1:0] ADDR_I,
	input  wire logic [31:0]       WDATA_I,
	input  wire logic              WR_I,
	input  wire logic              RD_I,
	output logic      [31:0]       RDATA_O,
	input  wire logic              PIXEL_SAMPLE_CLOCK_I,
	input  wire logic              FRAME_SYNC_I,
	input  wire logic              LINE_VALID_I,
	input  wire logic [PIX_W-1:0]  PIXEL_DATA_LINES_I,
	output logic                   DMA_REQ_O,
	input  wire logic              DMA_ACK_I,
	output logic      [31:0]       DMA_DATA_O
);

	logic [31:0]      ctrl_q;
	logic [31:0]      code_q;
	logic             overrun_q;
	logic             pclk_prev_q;
	logic             frame_prev_q;
	logic             emb_frame_q;
	logic             emb_line_q;
	logic [PIX_W-1:0] d0_q;
	logic [PIX_W-1:0] d1_q;
	logic [PIX_W-1:0] d2_q;
	logic             v0_q;
	logic             v1_q;
	logic             v2_q;
	logic [IN_W-1:0]  pins_s;
	logic             word_valid;
	logic [31:0]      word;

	cpc_sync #(.W(IN_W)) u_sync
	(
		.clk_i (CLK_I),
		.rst_i (RST_I),
		.d_i   ({PIXEL_SAMPLE_CLOCK_I, FRAME_SYNC_I, LINE_VALID_I, PIXEL_DATA_LINES_I}),
		.q_o   (pins_s)
	);

	wire              pclk_s    = pins_s[IN_W-1];
	wire              fsync_s   = pins_s[IN_W-2];
	wire              line_s    = pins_s[IN_W-3];
	wire  [PIX_W-1:0] data_s    = pins_s[PIX_W-1:0];

	wire              capture   = ctrl_q[B_CAPTURE];
	wire              embed     = ctrl_q[B_EMBED];
	wire              compress  = ctrl_q[B_COMPRESS];
	wire              fall      = ctrl_q[B_FALL];
	wire  cpc_width_t width     = cpc_width_t'(ctrl_q[B_WIDTH +: 2]);

	// Limitation: sampling through the synchroniser caps the pixel clock at CLK_I / PIX_MIN_CYCLES
	wire              sample_edge = fall ? (!pclk_s && pclk_prev_q)
	                                     : (pclk_s && !pclk_prev_q);

	// Unused upper lines read as zero; in 8-bit mode the board wires the sensor MSBs to lines 7..0
	wire  [PIX_W-1:0] sample_w  = (width == CPC_W8)  ? {6'h00, data_s[7:0]} :
	                              (width == CPC_W10) ? {4'h0, data_s[9:0]}  :
	                              (width == CPC_W12) ? {2'h0, data_s[11:0]} :
	                              data_s;

	// Embedded codes follow an FF 00 00 preamble held in the three-sample delay line
	wire              code_now  = embed && sample_edge && d2_q[7:0] == PRE_FF
	                              && d1_q[7:0] == PRE_00 && d0_q[7:0] == PRE_00;
	wire  [7:0]       code_byte = sample_w[7:0];
	wire              emb_fs    = code_now && code_byte == code_q[7:0];
	wire              emb_ls    = code_now && code_byte == code_q[15:8];
	wire              emb_le    = code_now && code_byte == code_q[23:16];
	wire              emb_fe    = code_now && code_byte == code_q[31:24];

	wire              frame_valid = fsync_s ^ ctrl_q[B_FSYNC_LOW];
	wire              disc_fs   = !embed && frame_valid && !frame_prev_q;
	wire              disc_fe   = !embed && !frame_valid && frame_prev_q;
	wire              frame_act = embed ? emb_frame_q : frame_valid;
	wire              line_act  = embed ? emb_line_q : line_s;

	wire              disc_take = compress ? line_s : (line_s && frame_valid);
	wire              emb_take  = v2_q && !code_now && (compress || emb_frame_q);
	wire              pack_valid = capture && sample_edge && (embed ? emb_take : disc_take);
	wire              restart   = !capture || disc_fs || emb_fs;
	wire              flush     = capture && compress && (disc_fe || emb_fe);
	wire              wide      = (width != CPC_W8);

	cpc_packer u_packer
	(
		.clk_i          (CLK_I),
		.rst_i          (RST_I),
		.restart_i      (restart),
		.flush_i        (flush),
		.wide_i         (wide),
		.sample_valid_i (pack_valid),
		.sample_i       (embed ? d2_q : sample_w),
		.word_valid_o   (word_valid),
		.word_o         (word)
	);

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			pclk_prev_q  <= 1'b0;
			frame_prev_q <= 1'b0;
			emb_frame_q  <= 1'b0;
			emb_line_q   <= 1'b0;
		end
		else
		begin
			pclk_prev_q  <= pclk_s;
			frame_prev_q <= frame_valid;
			if (emb_fs || emb_fe || !embed)
				emb_frame_q <= emb_fs;
			if (emb_ls || emb_le || emb_fe || !embed)
				emb_line_q <= emb_ls;
		end
	end

	// The delay line keeps preamble bytes out of the packer
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			d0_q <= '0;
			d1_q <= '0;
			d2_q <= '0;
			v0_q <= 1'b0;
			v1_q <= 1'b0;
			v2_q <= 1'b0;
		end
		else if (sample_edge)
		begin
			d0_q <= sample_w;
			d1_q <= d0_q;
			d2_q <= d1_q;
			v0_q <= emb_line_q && !code_now;
			v1_q <= v0_q && !code_now;
			v2_q <= v1_q && !code_now;
		end
	end

	// Only one word is held: the DMA engine owns all storage, so a late acknowledge loses data
	wire              new_req   = capture && word_valid;
	wire              over_set  = new_req && DMA_REQ_O && !DMA_ACK_I;
	wire              ctrl_wr   = WR_I && ADDR_I == OFF_CTRL;
	wire              code_wr   = WR_I && ADDR_I == OFF_CODE;
	wire              over_clr  = WR_I && ADDR_I == OFF_STAT && WDATA_I[B_OVERRUN];

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			DMA_REQ_O  <= 1'b0;
			DMA_DATA_O <= 32'h00000000;
			overrun_q  <= 1'b0;
		end
		else
		begin
			if (word_valid)
				DMA_DATA_O <= word;
			if (!capture)
				DMA_REQ_O <= 1'b0;
			else if (new_req)
				DMA_REQ_O <= 1'b1;
			else if (DMA_ACK_I)
				DMA_REQ_O <= 1'b0;
			if (over_set)
				overrun_q <= 1'b1;
			else if (over_clr)
				overrun_q <= 1'b0;
		end
	end

	wire  [31:0] stat_word = {28'h0000000, overrun_q, DMA_REQ_O, line_act, frame_act};
	wire  [31:0] rd_mux    = (ADDR_I == OFF_CTRL) ? ctrl_q :
	                         (ADDR_I == OFF_STAT) ? stat_word :
	                         (ADDR_I == OFF_DATA) ? DMA_DATA_O :
	                         (ADDR_I == OFF_CODE) ? code_q : 32'h00000000;

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ctrl_q  <= CTRL_RESET;
			code_q  <= CODE_RESET;
			RDATA_O <= 32'h00000000;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_q <= WDATA_I & CTRL_MASK;
			if (code_wr)
				code_q <= WDATA_I;
			RDATA_O <= RD_I ? rd_mux : 32'h00000000;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_req_needs_capture: assert property (DMA_REQ_O |-> capture)
		else $error("DMA request while capture is off");

	a_word_to_request: assert property (new_req |=> DMA_REQ_O && DMA_DATA_O == $past(word))
		else $error("Completed word did not raise a request with its data");

	a_request_held: assert property (DMA_REQ_O && !DMA_ACK_I && capture && !RST_I |=> DMA_REQ_O)
		else $error("Request dropped without acknowledge");

	a_edge_polarity: assert property (sample_edge |-> (fall ? $fell(pclk_s) : $rose(pclk_s)))
		else $error("Sample taken on the wrong pixel clock edge");

	a_narrow_mask: assert property (pack_valid && !embed && width == CPC_W8 |-> sample_w[13:8] == 6'h00)
		else $error("Upper lines leaked into an 8-bit sample");

	a_width_mask: assert property (pack_valid && !embed && width == CPC_W10 |-> sample_w == {4'h0, data_s[9:0]})
		else $error("10-bit sample not taken from the low ten lines");

	a_discrete_gate: assert property (pack_valid && !embed && !compress |-> line_s && frame_valid)
		else $error("Sample taken outside an active line and frame");

	a_code_dropped: assert property (code_now |-> !pack_valid)
		else $error("Sync code byte was packed as pixel data");

	a_flush_mode: assert property (flush |-> compress && capture)
		else $error("Partial word flushed outside compressed mode");

	a_read_latency: assert property (RD_I && ADDR_I == OFF_DATA |=> RDATA_O == $past(DMA_DATA_O))
		else $error("Data word read returned the wrong value");

	a_one_per_clock: assert property (sample_edge |=> !sample_edge)
		else $error("Two samples from one pixel clock period");

	a_off_no_sample: assert property (!capture |-> !pack_valid)
		else $error("Sample packed while capture is off");

	a_off_drops_req: assert property (!capture |=> !DMA_REQ_O)
		else $error("Request survived clearing the capture bit");

	a_ack_clears_req: assert property (DMA_REQ_O && DMA_ACK_I && !new_req |=> !DMA_REQ_O)
		else $error("Acknowledge did not retire the request");

	a_no_spurious_req: assert property (!DMA_REQ_O && !new_req |=> !DMA_REQ_O)
		else $error("Request raised without a completed word");

	a_data_stable: assert property (!word_valid |=> $stable(DMA_DATA_O))
		else $error("Data word changed without a new word");

	a_sample_on_edge: assert property (pack_valid |-> sample_edge)
		else $error("Sample packed between pixel clock edges");

	a_compress_gate: assert property (pack_valid && !embed && compress |-> line_s)
		else $error("Compressed sample taken outside line valid");

	a_embed_gate: assert property (pack_valid && embed && !compress |-> emb_frame_q)
		else $error("Embedded sample packed outside a frame");

	a_frame_restart: assert property (restart |=> !word_valid)
		else $error("Word emitted across a packing restart");

	// Overrun records a word that replaced one the DMA engine had not yet taken
	a_overrun_set: assert property (over_set |=> overrun_q)
		else $error("Overwritten word did not flag overrun");

	a_overrun_clear: assert property (over_clr && !over_set |=> !overrun_q)
		else $error("Overrun not cleared by a write of one");

	a_overrun_hold: assert property (!over_set && !over_clr |=> $stable(overrun_q))
		else $error("Overrun flag changed on its own");

	a_read_idle: assert property (!RD_I |=> RDATA_O == 32'h00000000)
		else $error("Read data not zero outside a read");

	a_ctrl_write: assert property (ctrl_wr |=> ctrl_q == ($past(WDATA_I) & CTRL_MASK))
		else $error("Control write not taken as masked");

	a_code_write: assert property (code_wr |=> code_q == $past(WDATA_I))
		else $error("Code write not taken");

	c_word_request:  cover property (new_req ##1 DMA_REQ_O ##[1:20] DMA_ACK_I);
	c_overrun:       cover property (over_set);
	c_embedded_sof:  cover property (emb_fs);
	c_compress_tail: cover property (flush && word_valid == 1'b0);
	c_fsync_low:     cover property (disc_fs && ctrl_q[B_FSYNC_LOW]);

endmodule // cpc_capture

// ==== testbench/cpc_sensor_model.sv ====
// Behavioural camera sensor that drives the parallel pixel pins of the capture port.
// Assumes the system clock paces it; the pixel clock stands low outside pixel transfers.
`timescale 1ns/1ps
module cpc_sensor_model
	import cpc_pkg::*;
(
	input  wire logic             clk_i,
	output logic                  pclk_o,
	output logic                  frame_o,
	output logic                  line_o,
	output logic      [PIX_W-1:0] data_o
);
	initial
	begin
		pclk_o  = 1'b0;
		frame_o = 1'b0;
		line_o  = 1'b0;
		data_o  = '0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Data is stable three clocks before and after either edge, so both polarities see it
	task automatic pixel(input logic [PIX_W-1:0] v);
		@(posedge clk_i);
		data_o <= v;
		wait_clk(3);
		pclk_o <= 1'b1;
		wait_clk(3);
		pclk_o <= 1'b0;
		wait_clk(2);
	endtask

	// Released data lines show the inverse so a stale sample cannot pass unnoticed
	task automatic line(input logic on);
		@(posedge clk_i);
		line_o <= on;
		if (!on)
			data_o <= ~data_o;
	endtask

	task automatic frame(input logic on);
		@(posedge clk_i);
		frame_o <= on;
	endtask
endmodule // cpc_sensor_model

// ==== testbench/camera_parallel_capture_test.sv ====
// Self-checking bench for the parallel pixel capture port.
// Assumes the sensor model on the pixel pins and the bench acting as register master and DMA engine.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module camera_parallel_capture_test;
	import cpc_pkg::*;
	logic              clk = 1'b0;
	logic              rst;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata;
	logic              wr;
	logic              rd;
	logic              ack;
	logic [31:0]       rdata;
	logic [31:0]       dma_data;
	logic              req;
	logic              pclk;
	logic              fsync;
	logic              lval;
	logic [PIX_W-1:0]  pdata;
	int                fail_count = 0;
	int                checks_done = 0;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	cpc_capture dut
	(
		.CLK_I                (clk),
		.RST_I                (rst),
		.ADDR_I               (addr),
		.WDATA_I              (wdata),
		.WR_I                 (wr),
		.RD_I                 (rd),
		.RDATA_O              (rdata),
		.PIXEL_SAMPLE_CLOCK_I (pclk),
		.FRAME_SYNC_I         (fsync),
		.LINE_VALID_I         (lval),
		.PIXEL_DATA_LINES_I   (pdata),
		.DMA_REQ_O            (req),
		.DMA_ACK_I            (ack),
		.DMA_DATA_O           (dma_data)
	);

	cpc_sensor_model cam
	(
		.clk_i   (clk),
		.pclk_o  (pclk),
		.frame_o (fsync),
		.line_o  (lval),
		.data_o  (pdata)
	);

	task automatic end_sim();
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 `CHK(rdata, exp)
	endtask

	task automatic send_bytes(input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++)
			cam.pixel({6'h00, w[8*i +: 8]});
	endtask

	// Plays the DMA engine: one request per word, cleared by a one-cycle acknowledge
	task automatic take_word(input logic [31:0] exp);
		int n;
		for (n = 0; n < 60 && req !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK(req, 1'b1)
		`CHK(dma_data, exp)
		rd_chk(OFF_DATA, exp);
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		@(posedge clk);
		#1 `CHK(req, 1'b0)
	endtask

	task automatic t_regs();
		rd_chk(OFF_CTRL, CTRL_RESET);
		rd_chk(OFF_CODE, CODE_RESET);
		rd_chk(4'h2, 32'h00000000);
		wr_reg(OFF_CTRL, 32'hFFFFFFFF);
		rd_chk(OFF_CTRL, CTRL_MASK);
		wr_reg(OFF_CTRL, 32'h00000000);
	endtask

	// Every width under both sampling edges; 8-bit mode has junk on the unused upper lines
	task automatic t_widths();
		logic [31:0]      exp;
		logic [PIX_W-1:0] s;
		for (int w = 0; w < 4; w++)
			for (int f = 0; f < 2; f++)
			begin
				wr_reg(OFF_CTRL, 32'h1 | (w << B_WIDTH) | (f << B_FALL));
				cam.frame(1'b1);
				cam.line(1'b1);
				exp = 32'h00000000;
				for (int i = 0; i < ((w == 0) ? 4 : 2); i++)
				begin
					s = (w == 0) ? 14'((i + 1) * 8'h11 + f) : (14'h2A5C ^ 14'(i * 14'h1111)) & 14'((1 << (8 + 2 * w)) - 1);
					if (w == 0)
						exp[8*i +: 8] = s[7:0];
					else
						exp[16*i +: 16] = {2'b00, s};
					cam.pixel((w == 0) ? {6'h3F, s[7:0]} : s);
				end
				cam.line(1'b0);
				cam.frame(1'b0);
				take_word(exp);
			end
	endtask

	task automatic t_gating();
		wr_reg(OFF_CTRL, 32'h00000000);
		cam.frame(1'b1);
		cam.line(1'b1);
		send_bytes(32'h44332211, 4);
		cam.line(1'b0);
		cam.wait_clk(20);
		#1 `CHK(req, 1'b0)
		cam.frame(1'b0);
		wr_reg(OFF_CTRL, 32'h00000001);
		cam.frame(1'b1);
		send_bytes(32'h00005555, 2);
		cam.line(1'b1);
		send_bytes(32'h0000A2A1, 2);
		cam.line(1'b0);
		cam.frame(1'b0);
		cam.wait_clk(4);
		cam.frame(1'b1);
		cam.line(1'b1);
		send_bytes(32'hB4B3B2B1, 4);
		cam.line(1'b0);
		cam.frame(1'b0);
		take_word(32'hB4B3B2B1);
	endtask

	// Compressed data needs no frame, and frame end pushes out a padded partial word
	task automatic t_compress();
		wr_reg(OFF_CTRL, 32'h00000005);
		cam.line(1'b1);
		send_bytes(32'hC4C3C2C1, 4);
		cam.line(1'b0);
		take_word(32'hC4C3C2C1);
		cam.frame(1'b1);
		cam.line(1'b1);
		send_bytes(32'h0000D2D1, 2);
		cam.line(1'b0);
		cam.frame(1'b0);
		take_word(32'h0000D2D1);
	endtask

	// A framed line with the given codes; a code table the design ignored would leave no word
	task automatic t_embedded(input logic [31:0] codes);
		wr_reg(OFF_CTRL, 32'h00000003);
		wr_reg(OFF_CODE, codes);
		rd_chk(OFF_CODE, codes);
		send_bytes({codes[7:0], 24'h0000FF}, 4);
		send_bytes({codes[15:8], 24'h0000FF}, 4);
		send_bytes(32'hE4E3E2E1, 4);
		send_bytes({codes[23:16], 24'h0000FF}, 4);
		send_bytes({codes[31:24], 24'h0000FF}, 4);
		take_word(32'hE4E3E2E1);
	endtask

	// Active-low frame sync, the status bits, and a word overwritten before its acknowledge
	task automatic t_status();
		wr_reg(OFF_CTRL, 32'h00000001 | (1 << B_FSYNC_LOW));
		rd_chk(OFF_STAT, 32'h00000001);
		cam.line(1'b1);
		send_bytes(32'h54535251, 4);
		send_bytes(32'h58575655, 4);
		rd_chk(OFF_STAT, 32'h0000000F);
		cam.line(1'b0);
		take_word(32'h58575655);
		rd_chk(OFF_STAT, 32'h00000009);
		wr_reg(OFF_STAT, 32'h00000008);
		rd_chk(OFF_STAT, 32'h00000001);
		cam.frame(1'b1);
		cam.wait_clk(3);
		rd_chk(OFF_STAT, 32'h00000000);
		cam.frame(1'b0);
		wr_reg(OFF_CTRL, 32'h00000000);
	endtask

	initial
	begin
		rst   = 1'b1;
		addr  = '0;
		wdata = 32'h00000000;
		wr    = 1'b0;
		rd    = 1'b0;
		ack   = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_widths();
		t_gating();
		t_compress();
		t_embedded(CODE_RESET);
		t_embedded(32'h5A3C9617);
		t_status();
		end_sim();
	end

	// The whole sequence needs about a thousand clocks; this bound only catches a hang
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		fail_count++;
		end_sim();
	end
endmodule // camera_parallel_capture_test
